// ### design/urx_cfg.svh
`ifndef URX_CFG_SVH
`define URX_CFG_SVH

// Register byte offsets
`define URX_OFF_STATUS 12'h000
`define URX_OFF_CTRL 12'h004
`define URX_OFF_FRAME 12'h008
`define URX_OFF_DATA 12'h00C
`define URX_OFF_BAUD 12'h010

// Status register fields
`define URX_ST_PE 2
`define URX_ST_OVR 3
`define URX_ST_FE 4
`define URX_ST_RXC 7
`define URX_ST_NINTH 8

// Control register fields
`define URX_CT_EN 0
`define URX_CT_DBL 1

// Frame config fields
`define URX_FC_SIZE_LSB 0
`define URX_FC_PAR_ODD 3
`define URX_FC_PAR_EN 4
`define URX_FC_STOP2 5

// Reset values
`define URX_CTRL_RST 2'h0
`define URX_FRAME_RST 6'h03
`define URX_BAUD_RST 16'h0000

// Samples per bit, vote positions and buffer depth
`define URX_SPB_NORM 5'd16
`define URX_SPB_DBL 5'd8
`define URX_VOTE_NORM 5'd8
`define URX_VOTE_DBL 5'd4
`define URX_FIFO_DEPTH 2

`endif

// ### design/urx_pkg.sv
package urx_pkg;

  typedef enum logic [3:0] {
    URX_IDLE = 4'b0001,
    URX_START = 4'b0010,
    URX_BITS = 4'b0100,
    URX_STOPB = 4'b1000
  } urx_state_t;

  // One buffered character with its status
  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic ovr;
    logic pe;
  } urx_entry_t;

  typedef struct packed {
    logic en;
    logic dbl;
    logic [2:0] size;
    logic par_odd;
    logic par_en;
    logic stop2;
    logic [15:0] baud;
  } urx_cfg_t;

endpackage : urx_pkg

// ### design/urx_top.sv
// Summary of operation
// - Error flags stored with each buffered character
// - Writes to error flag bits ignored
// - Error flags raise no interrupt
// - Frame error shows first stop bit low
// - Only first stop bit is checked
// - Overrun: buffer full, shifter full, start
// - Overrun cleared on successful buffer transfer
// - Parity checked when enabled, odd or even
// - Parity result buffered until data read
// - Parity error only if enabled and mismatch
// - Disable stops reception at once
// - Disable flushes receive buffer
// - Sample at 16x, or 8x double speed
// - Start validated by samples 8-10 or 4-6
// - Majority high rejects start; resync each
// - Sixteen or eight states per bit
// - Each bit is majority of centre samples
// - Stop bit zero records frame error
// - New start accepted after stop voting
// - Receive complete reflects buffer not empty
// - Ninth bit buffered per character
// - Completed character moved into buffer
`timescale 1ns/100ps
`include "urx_cfg.svh"

module urx_top (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic serial_receive_pin_i,
  output logic rx_pin_override_o
);
  import urx_pkg::*;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `URX_OFF_STATUS) || (a == `URX_OFF_CTRL) ||
      (a == `URX_OFF_FRAME) || (a == `URX_OFF_DATA) ||
      (a == `URX_OFF_BAUD);
  endfunction : is_mapped

  // Size code 7 selects nine bits; codes 4 to 6 fold onto 5 to 7
  function automatic logic [3:0] data_bits(input logic [2:0] size);
    if (size == 3'h7) begin
      data_bits = 4'h9;
    end else begin
      data_bits = 4'h5 + {2'h0, size[1:0]};
    end
  endfunction : data_bits

  // APB registers
  urx_cfg_t cfg_r, cfg_nxt;
  // First access cycle captures read data, the second one answers
  logic ack_r, ack_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  // Baud divider
  logic [15:0] div_r, div_nxt;
  logic tick;
  // Receiver
  urx_state_t state_r, state_nxt;
  logic [4:0] smp_r, smp_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [2:0] win_r, win_nxt;
  logic [8:0] shf_r, shf_nxt;
  logic par_r, par_nxt;
  logic prev_r, prev_nxt;
  logic hold_r, hold_nxt;
  urx_entry_t hold_ent_r, hold_ent_nxt;
  logic ovr_pend_r, ovr_pend_nxt;
  // Buffer
  urx_entry_t fifo_r [`URX_FIFO_DEPTH];
  urx_entry_t fifo_nxt [`URX_FIFO_DEPTH];
  logic rd_ptr_r, rd_ptr_nxt;
  logic wr_ptr_r, wr_ptr_nxt;
  logic [1:0] cnt_r, cnt_nxt;

  logic acc, wr_acc, rd_acc;
  logic data_read;
  logic [4:0] spb, vote;
  logic [3:0] nbits;
  logic [3:0] ndata;
  urx_entry_t head;
  logic fifo_full, push, pop;
  logic bitval, last_smp, fe_bit, pe_bit;

  assign acc = psel_i & penable_i;
  // Writes land on the answering edge; reads and pops on the first
  assign wr_acc = acc & pwrite_i & ack_r;
  assign rd_acc = acc & ~pwrite_i & ~ack_r;
  assign data_read = rd_acc & (paddr_i == `URX_OFF_DATA);
  assign pready_o = ack_r;
  assign prdata_o = prdata_r;
  assign pslverr_o = pslverr_r;
  assign rx_pin_override_o = cfg_r.en;
  // No interrupt output exists for the error flags

  assign spb = cfg_r.dbl ? `URX_SPB_DBL : `URX_SPB_NORM;
  assign vote = cfg_r.dbl ? `URX_VOTE_DBL : `URX_VOTE_NORM;
  assign ndata = data_bits(cfg_r.size);
  assign nbits = ndata + {3'h0, cfg_r.par_en};
  assign head = fifo_r[rd_ptr_r];
  assign fifo_full = (cnt_r == 2'h2);
  assign last_smp = (smp_r == spb);
  assign bitval = maj3(win_r);

  // Register file and read data
  always_comb begin
    cfg_nxt = cfg_r;
    prdata_nxt = prdata_r;
    ack_nxt = acc & ~ack_r;
    // Error stands in the answering cycle only
    pslverr_nxt = acc & ~ack_r & ~is_mapped(paddr_i);
    if (wr_acc) begin
      unique case (paddr_i)
        `URX_OFF_STATUS: begin
          // Error flag positions are read-only
          cfg_nxt = cfg_r;
        end
        `URX_OFF_CTRL: begin
          cfg_nxt.en = pwdata_i[`URX_CT_EN];
          cfg_nxt.dbl = pwdata_i[`URX_CT_DBL];
        end
        `URX_OFF_FRAME: begin
          cfg_nxt.size = pwdata_i[`URX_FC_SIZE_LSB +: 3];
          cfg_nxt.par_odd = pwdata_i[`URX_FC_PAR_ODD];
          cfg_nxt.par_en = pwdata_i[`URX_FC_PAR_EN];
          cfg_nxt.stop2 = pwdata_i[`URX_FC_STOP2];
        end
        `URX_OFF_BAUD: cfg_nxt.baud = pwdata_i[15:0];
        `URX_OFF_DATA: cfg_nxt = cfg_r;
        default: cfg_nxt = cfg_r;
      endcase
    end
    if (rd_acc) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr_i)
        `URX_OFF_STATUS: begin
          prdata_nxt[`URX_ST_RXC] = (cnt_r != 2'h0);
          prdata_nxt[`URX_ST_FE] = (cnt_r != 2'h0) & head.fe;
          prdata_nxt[`URX_ST_OVR] = (cnt_r != 2'h0) & head.ovr;
          prdata_nxt[`URX_ST_PE] = (cnt_r != 2'h0) & head.pe;
          prdata_nxt[`URX_ST_NINTH] = (cnt_r != 2'h0) & head.data[8];
        end
        `URX_OFF_CTRL: begin
          prdata_nxt[`URX_CT_EN] = cfg_r.en;
          prdata_nxt[`URX_CT_DBL] = cfg_r.dbl;
        end
        `URX_OFF_FRAME: begin
          prdata_nxt[`URX_FC_SIZE_LSB +: 3] = cfg_r.size;
          prdata_nxt[`URX_FC_PAR_ODD] = cfg_r.par_odd;
          prdata_nxt[`URX_FC_PAR_EN] = cfg_r.par_en;
          prdata_nxt[`URX_FC_STOP2] = cfg_r.stop2;
        end
        `URX_OFF_DATA: begin
          if (cnt_r != 2'h0) begin
            prdata_nxt[7:0] = head.data[7:0];
          end
        end
        `URX_OFF_BAUD: prdata_nxt[15:0] = cfg_r.baud;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cfg_r <= '{en: 1'b0, dbl: 1'b0, size: 3'h3, par_odd: 1'b0,
        par_en: 1'b0, stop2: 1'b0, baud: `URX_BAUD_RST};
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      ack_r <= ack_nxt;
    end
  end

  // Sample-rate enable divider
  always_comb begin
    tick = 1'b0;
    div_nxt = div_r - 16'h0001;
    // Held at reload while disabled
    if (!cfg_r.en || div_r == 16'h0000) begin
      div_nxt = cfg_r.baud;
      tick = cfg_r.en;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Clock and data recovery
  always_comb begin
    state_nxt = state_r;
    smp_nxt = smp_r;
    bit_nxt = bit_r;
    win_nxt = win_r;
    shf_nxt = shf_r;
    par_nxt = par_r;
    prev_nxt = prev_r;
    hold_nxt = hold_r;
    hold_ent_nxt = hold_ent_r;
    ovr_pend_nxt = ovr_pend_r;
    fe_bit = 1'b0;
    pe_bit = 1'b0;
    // Cleared before the tick so a capture or a new start wins
    if (push) begin
      hold_nxt = 1'b0;
      ovr_pend_nxt = 1'b0;
    end
    if (tick) begin
      prev_nxt = serial_receive_pin_i;
      if (smp_r >= vote && smp_r <= vote + 5'd2) begin
        win_nxt = {win_r[1:0], serial_receive_pin_i};
      end
      smp_nxt = smp_r + 5'd1;
      unique case (state_r)
        URX_IDLE: begin
          smp_nxt = 5'd2;
          // Falling edge, first low sample is sample 1
          if (prev_r && !serial_receive_pin_i) begin
            state_nxt = URX_START;
            win_nxt = 3'h0;
            // Held character will be overwritten: mark the loss
            if (fifo_full && hold_r) begin
              ovr_pend_nxt = 1'b1;
            end
          end
        end
        URX_START: begin
          if (smp_r == vote + 5'd3) begin
            if (maj3(win_r)) begin
              state_nxt = URX_IDLE;
              prev_nxt = 1'b1;
            end
          end
          if (last_smp) begin
            smp_nxt = 5'd1;
            bit_nxt = 4'h0;
            shf_nxt = 9'h000;
            par_nxt = cfg_r.par_odd;
            if (state_nxt == URX_START) begin
              state_nxt = URX_BITS;
            end
          end
        end
        URX_BITS: begin
          if (last_smp) begin
            smp_nxt = 5'd1;
            bit_nxt = bit_r + 4'h1;
            if (bit_r < ndata) begin
              shf_nxt[bit_r] = bitval;
              par_nxt = par_r ^ bitval;
            end else begin
              par_nxt = par_r ^ bitval;
            end
            if (bit_r + 4'h1 == nbits) begin
              state_nxt = URX_STOPB;
            end
          end
        end
        URX_STOPB: begin
          // Decide right after the last vote sample
          if (smp_r == vote + 5'd3) begin
            fe_bit = ~bitval;
            pe_bit = cfg_r.par_en & par_r;
            hold_nxt = 1'b1;
            hold_ent_nxt = '{data: shf_r, fe: fe_bit,
              ovr: ovr_pend_r, pe: pe_bit};
            state_nxt = URX_IDLE;
            // A held-low break must not look like a fresh edge
            prev_nxt = bitval | serial_receive_pin_i;
          end
        end
        default: state_nxt = URX_IDLE;
      endcase
    end
    if (!cfg_r.en) begin
      state_nxt = URX_IDLE;
      prev_nxt = 1'b1;
      hold_nxt = 1'b0;
      ovr_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_r <= URX_IDLE;
      smp_r <= 5'd0;
      bit_r <= 4'h0;
      win_r <= 3'h0;
      shf_r <= 9'h000;
      par_r <= 1'b0;
      prev_r <= 1'b1;
      hold_r <= 1'b0;
      hold_ent_r <= '0;
      ovr_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      smp_r <= smp_nxt;
      bit_r <= bit_nxt;
      win_r <= win_nxt;
      shf_r <= shf_nxt;
      par_r <= par_nxt;
      prev_r <= prev_nxt;
      hold_r <= hold_nxt;
      hold_ent_r <= hold_ent_nxt;
      ovr_pend_r <= ovr_pend_nxt;
    end
  end

  // Two-entry receive buffer
  assign pop = data_read & (cnt_r != 2'h0);
  assign push = hold_r & cfg_r.en & (!fifo_full | pop);

  always_comb begin
    fifo_nxt = fifo_r;
    rd_ptr_nxt = rd_ptr_r;
    wr_ptr_nxt = wr_ptr_r;
    cnt_nxt = cnt_r;
    if (push) begin
      fifo_nxt[wr_ptr_r] = hold_ent_r;
      wr_ptr_nxt = ~wr_ptr_r;
    end
    if (pop) begin
      rd_ptr_nxt = ~rd_ptr_r;
    end
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    if (!cfg_r.en) begin
      rd_ptr_nxt = 1'b0;
      wr_ptr_nxt = 1'b0;
      cnt_nxt = 2'h0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fifo_r <= '{default: '0};
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      fifo_r <= fifo_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule : urx_top

// ### dv/urx_tx_model.sv
`timescale 1ns/100ps
module urx_tx_model (
  input wire logic clk_i,
  output logic line_o
);
  initial line_o = 1'b1;
  task automatic put(input logic v, input int n);
    line_o <= v;
    repeat (n) @(posedge clk_i);
  endtask : put
  // Start, data LSB first, optional parity (pb < 0: none), stop
  task automatic send(input logic [8:0] d, input int nd, input int bc,
                      input int pb, input logic sb);
    put(1'b0, bc);
    for (int i = 0; i < nd; i++) put(d[i], bc);
    if (pb >= 0) put(pb[0], bc);
    put(sb, bc);
    // Bad stop: line back high before next start
    if (!sb) put(1'b1, bc);
  endtask : send
endmodule : urx_tx_model

// ### dv/urx_asserts.sv
`timescale 1ns/100ps
`include "urx_cfg.svh"
module urx_asserts (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic serial_receive_pin_i,
  input wire logic rx_pin_override_o
);
  logic acc, ctl_wr, rd_st_nxt, rd_st_r;
  assign acc = psel_i & penable_i;
  assign ctl_wr = acc & pready_o & pwrite_i & (paddr_i == `URX_OFF_CTRL);
  always_comb begin
    rd_st_nxt = acc & !pwrite_i & (paddr_i == `URX_OFF_STATUS);
    if (sys_rst_i) rd_st_nxt = 1'b0;
  end
  always_ff @(posedge core_clk_i) rd_st_r <= rd_st_nxt;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  ready_wait_a: assert property (acc && !pready_o |=> pready_o)
    else $error("pready late");
  slverr_bad_a: assert property (acc && !pready_o &&
    paddr_i > `URX_OFF_BAUD |=> pslverr_o) else $error("no slave error");
  slverr_ok_a: assert property (acc && paddr_i inside {12'h000, 12'h004,
    12'h008, 12'h00C, 12'h010} |=> !pslverr_o) else $error("slverr");
  slverr_src_a: assert property (pslverr_o |-> $past(acc))
    else $error("stray slverr");
  rdata_hold_a: assert property (!(acc && !pwrite_i) |=>
    $stable(prdata_o)) else $error("prdata moved");
  enable_set_a: assert property (ctl_wr |=>
    rx_pin_override_o == $past(pwdata_i[0])) else $error("enable");
  enable_hold_a: assert property (!ctl_wr |=>
    $stable(rx_pin_override_o)) else $error("enable moved");
  flush_empty_a: assert property (rd_st_nxt && !rx_pin_override_o &&
    !$past(rx_pin_override_o) |=> !prdata_o[`URX_ST_RXC])
    else $error("not flushed");
  empty_flags_a: assert property (rd_st_r && !prdata_o[`URX_ST_RXC] |->
    prdata_o[`URX_ST_NINTH:`URX_ST_PE] == 7'h00) else $error("flags");
endmodule : urx_asserts
bind urx_top urx_asserts u_chk (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .serial_receive_pin_i(serial_receive_pin_i),
  .rx_pin_override_o(rx_pin_override_o));

// ### dv/uart_rx_recovery_errors_test.sv
`timescale 1ns/100ps
`include "urx_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module uart_rx_recovery_errors_test;
  logic clk, rst, psel, pen, pwr, pready, pslverr, rxd, ovr_pin;
  logic rerr;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, prdata;
  logic [7:0] d;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int k = 0;
  urx_top u_dut (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .serial_receive_pin_i(rxd), .rx_pin_override_o(ovr_pin));
  urx_tx_model u_tx (.clk_i(clk), .line_o(rxd));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    // Answer taken at the edge that samples pready high
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask : wr
  task automatic rc(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rdata)
  endtask : rc
  // Status first, then data
  task automatic pop(input logic [31:0] s, input logic [31:0] v);
    rc("status", `URX_OFF_STATUS, s);
    rc("data", `URX_OFF_DATA, v);
  endtask : pop
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    addr = 12'h000;
    wdata = 32'h0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc("status", `URX_OFF_STATUS, 32'h0);
    rc("ctrl", `URX_OFF_CTRL, 32'h0);
    rc("frame", `URX_OFF_FRAME, 32'h3);
    bus(1'b0, 12'h014, 32'h0);
    `CHK("slverr", 1'b1, rerr)
    wr(`URX_OFF_BAUD, 32'h1);
    wr(`URX_OFF_FRAME, 32'h23);
    wr(`URX_OFF_CTRL, 32'h1);
    u_tx.send(9'h0A5, 8, 32, -1, 1'b1);
    `CHK("override", 1'b1, ovr_pin)
    u_tx.send(9'h03C, 8, 32, -1, 1'b0);
    u_tx.send(9'h05A, 8, 32, -1, 1'b1);
    repeat (16) @(posedge clk);
    pop(32'h080, 32'hA5);
    wr(`URX_OFF_STATUS, 32'h0);
    pop(32'h090, 32'h3C);
    pop(32'h080, 32'h5A);
    for (int i = 0; i < 4; i++) begin
      wr(`URX_OFF_FRAME, i[0] ? 32'h1B : 32'h13);
      d = 8'h36 + 8'(i);
      u_tx.send({1'b0, d}, 8, 32, int'((^d) ^ i[0] ^ i[1]), 1'b1);
      repeat (16) @(posedge clk);
      pop(i[1] ? 32'h084 : 32'h080, {24'h0, d});
    end
    wr(`URX_OFF_FRAME, 32'h07);
    u_tx.send(9'h1A5, 9, 32, -1, 1'b1);
    repeat (16) @(posedge clk);
    pop(32'h180, 32'hA5);
    wr(`URX_OFF_FRAME, 32'h03);
    for (int i = 1; i < 5; i++) u_tx.send(9'(i * 17), 8, 32, -1, 1'b1);
    repeat (16) @(posedge clk);
    pop(32'h080, 32'h11);
    pop(32'h080, 32'h22);
    rc("overrun", `URX_OFF_STATUS, 32'h088);
    do begin
      bus(1'b0, `URX_OFF_DATA, 32'h0);
      bus(1'b0, `URX_OFF_STATUS, 32'h0);
    end while (rdata[7] === 1'b1 && ++k < 3);
    `CHK("flushed", 1'b0, rdata[7])
    // Short low pulse must be taken as noise
    u_tx.put(1'b0, 6);
    u_tx.put(1'b1, 64);
    u_tx.send(9'h055, 8, 32, -1, 1'b1);
    repeat (16) @(posedge clk);
    pop(32'h080, 32'h55);
    wr(`URX_OFF_CTRL, 32'h3);
    u_tx.send(9'h0C3, 8, 16, -1, 1'b1);
    repeat (16) @(posedge clk);
    pop(32'h080, 32'hC3);
    u_tx.send(9'h081, 8, 16, -1, 1'b1);
    fork
      u_tx.send(9'h042, 8, 16, -1, 1'b1);
    join_none
    repeat (60) @(posedge clk);
    wr(`URX_OFF_CTRL, 32'h0);
    wait fork;
    `CHK("released", 1'b0, ovr_pin)
    rc("disabled", `URX_OFF_STATUS, 32'h0);
    wr(`URX_OFF_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    rc("aborted", `URX_OFF_STATUS, 32'h0);
    test_done();
  end
endmodule : uart_rx_recovery_errors_test
